// *** verilog/charger_rail_irq_status.sv ***
// Charger and rail status, mask and acknowledge logic driving the interrupt pin
//
// Overview of operation
// - USB status bit follows valid USB source
// - Adapter status bit follows valid adapter source
// - Thermal suspend bit set on rise of charging halt
// - Termination bit high after current crossed threshold
// - Timer off: bit 3 follows taper comparator
// - Timer on: taper reported after thirty minutes
// - Timeout bits report expired charger timers
// - Battery temperature error bit set on rise of condition
// - Writes to bits 1-4 reset charger only
// - Unmasked charge status bit asserts interrupt
// - Push-button request sets rail bit 7
// - Undervoltage sets rail bit 5
// - Rail bit 4 always reads zero
// - Linear regulator fault gated by enable
// - Main converter fault on rail bit 1
// - Core fault or selected low-power mode, bit 0
// - Rail bit rise drives interrupt unless masked
// - Charge mask blocks bits, resets all ones
// - Rail mask blocks bits, resets all ones
// - Acknowledged bit no longer drives interrupt
// - Acknowledge clears when status clears
// - Reading status acknowledges every set bit
// - Charge bits 5,0 edge set, others level
// - Rail bits 7-5 edge set, others level
`timescale 1ns/1ps
`default_nettype none
module charger_rail_irq_status #(
   parameter logic [charger_rail_irq_pkg::TAPER_CNT_W-1:0] TAPER_DELAY_CYCLES =
      charger_rail_irq_pkg::TAPER_DELAY_CYCLES
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Register port from the serial engine
   input wire charger_rail_irq_pkg::reg_req_t i_reg_req,
   output logic [7:0] o_reg_rdata,
   // Asynchronous conditions
   input wire charger_rail_irq_pkg::chg_cond_t i_chg_cond,
   input wire charger_rail_irq_pkg::rail_cond_t i_rail_cond,
   // Configuration bits from the device's setup registers
   input wire logic i_taper_timer_en,
   input wire logic i_aux_linear_reg_a_en,
   input wire logic i_aux_linear_reg_b_en,
   input wire logic i_core_lowpower_sel,
   // Charger restart request
   output logic o_charger_reset,
   // Open-drain interrupt pin
   output logic o_int_out,
   output logic o_int_oe_n
);

   charger_rail_irq_pkg::state_t st;
   charger_rail_irq_pkg::state_t next_st;

   logic [7:0] chg_cond;
   logic [7:0] rail_cond;
   logic [7:0] chg_rise;
   logic [7:0] rail_rise;
   logic [7:0] chg_pending;
   logic [7:0] rail_pending;
   logic rd_chg;
   logic rd_rail;
   logic wr_chg_reset;

   // Assertion clock and reset
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);

   always_comb begin
      chg_cond = st.chg_sync2;
      // Bit 3 is the comparator itself or the expired taper timer
      chg_cond[charger_rail_irq_pkg::CHG_TAPER_BIT] = i_taper_timer_en ?
         st.taper_done :
         st.chg_sync2[charger_rail_irq_pkg::CHG_TAPER_BIT];
   end

   always_comb begin
      rail_cond = st.rail_sync2;
      rail_cond[6] = ~st.rail_sync2[6];
      rail_cond[charger_rail_irq_pkg::RAIL_UNUSED_BIT] = 1'b0;
      rail_cond[3] = st.rail_sync2[3] & i_aux_linear_reg_b_en;
      rail_cond[2] = st.rail_sync2[2] & i_aux_linear_reg_a_en;
      rail_cond[0] = st.rail_sync2[0] |
         (i_core_lowpower_sel & st.rail_sync2[charger_rail_irq_pkg::RAIL_UNUSED_BIT]);
   end

   assign chg_rise = chg_cond & ~st.chg_prev;
   assign rail_rise = rail_cond & ~st.rail_prev;

   // Acknowledged or masked bits do not reach the pin
   assign chg_pending = st.chg_stat & ~st.mask_chg & ~st.chg_ack;
   assign rail_pending = st.rail_stat & ~st.mask_rail & ~st.rail_ack;

   assign rd_chg = i_reg_req.rd &&
      (i_reg_req.addr == charger_rail_irq_pkg::ADDR_CHG_STATUS);
   assign rd_rail = i_reg_req.rd &&
      (i_reg_req.addr == charger_rail_irq_pkg::ADDR_RAIL_STATUS);
   assign wr_chg_reset = i_reg_req.wr &&
      (i_reg_req.addr == charger_rail_irq_pkg::ADDR_CHG_STATUS) &&
      ((i_reg_req.wdata & charger_rail_irq_pkg::CHG_RESET_BITS) != 8'h00);

   always_comb begin
      next_st = st;

      // Two-stage synchronisers and edge history
      next_st.chg_sync1 = i_chg_cond;
      next_st.chg_sync2 = st.chg_sync1;
      next_st.rail_sync1 = i_rail_cond;
      next_st.rail_sync2 = st.rail_sync1;
      next_st.chg_prev = chg_cond;
      next_st.rail_prev = rail_cond;

      // Taper timer restarts on comparator drop, disable or charger reset
      if (!i_taper_timer_en || wr_chg_reset ||
          !st.chg_sync2[charger_rail_irq_pkg::CHG_TAPER_BIT]) begin
         next_st.taper_cnt = '0;
         next_st.taper_done = 1'b0;
      end else if (st.taper_cnt >= TAPER_DELAY_CYCLES - 40'h1) begin
         next_st.taper_done = 1'b1;
      end else begin
         next_st.taper_cnt = st.taper_cnt + 40'h1;
      end

      // Edge bits: set on rise, clear once low and acknowledged; rise wins
      next_st.chg_stat = (chg_rise | (st.chg_stat & ~(~chg_cond & st.chg_ack))) &
         charger_rail_irq_pkg::CHG_EDGE_BITS;
      // Level bits copy the condition
      next_st.chg_stat = next_st.chg_stat |
         (chg_cond & ~charger_rail_irq_pkg::CHG_EDGE_BITS);

      next_st.rail_stat = (rail_rise | (st.rail_stat & ~(~rail_cond & st.rail_ack))) &
         charger_rail_irq_pkg::RAIL_EDGE_BITS;
      next_st.rail_stat = next_st.rail_stat |
         (rail_cond & ~charger_rail_irq_pkg::RAIL_EDGE_BITS);

      // Reading acknowledges set bits; a cleared status drops its ack
      next_st.chg_ack = (st.chg_ack | (rd_chg ? st.chg_stat : 8'h00)) &
         next_st.chg_stat;
      next_st.rail_ack = (st.rail_ack | (rd_rail ? st.rail_stat : 8'h00)) &
         next_st.rail_stat;

      // Only bits 4..1 of charge status take writes, as a charger restart
      next_st.chg_reset = wr_chg_reset;

      if (i_reg_req.wr) begin
         case (i_reg_req.addr)
            charger_rail_irq_pkg::ADDR_CHG_MASK: begin
               next_st.mask_chg = i_reg_req.wdata;
            end
            charger_rail_irq_pkg::ADDR_RAIL_MASK: begin
               next_st.mask_rail = i_reg_req.wdata;
            end
            default: begin
            end
         endcase
      end

      if (i_reg_req.rd) begin
         case (i_reg_req.addr)
            charger_rail_irq_pkg::ADDR_CHG_STATUS: next_st.rdata = st.chg_stat;
            charger_rail_irq_pkg::ADDR_RAIL_STATUS: next_st.rdata = st.rail_stat;
            charger_rail_irq_pkg::ADDR_CHG_MASK: next_st.rdata = st.mask_chg;
            charger_rail_irq_pkg::ADDR_RAIL_MASK: next_st.rdata = st.mask_rail;
            charger_rail_irq_pkg::ADDR_CHG_ACK: next_st.rdata = st.chg_ack;
            charger_rail_irq_pkg::ADDR_RAIL_ACK: next_st.rdata = st.rail_ack;
            default: next_st.rdata = charger_rail_irq_pkg::UNMAPPED_READ;
         endcase
      end

      // Pin pulled low while anything is pending
      next_st.int_oe_n = ~(|chg_pending | |rail_pending);
      next_st.int_drive = 1'b0;
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         st <= charger_rail_irq_pkg::STATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign o_reg_rdata = st.rdata;
   assign o_charger_reset = st.chg_reset;
   assign o_int_out = st.int_drive;
   assign o_int_oe_n = st.int_oe_n;

   // Checks
   property p_mask_reset;
      $past(i_reset) |-> (st.mask_chg == 8'hFF) && (st.mask_rail == 8'hFF);
   endproperty
   a_mask_reset: assert property (p_mask_reset)
      else $error("masks not all ones after reset");

   property p_usb_level;
      ##1 st.chg_stat[7] == $past(st.chg_sync2[7]);
   endproperty
   a_usb_level: assert property (p_usb_level)
      else $error("usb status does not follow condition");

   property p_rail_bit4;
      st.rail_stat[4] == 1'b0;
   endproperty
   a_rail_bit4: assert property (p_rail_bit4)
      else $error("rail bit 4 set");

   property p_ldo_gate;
      ##1 !$past(i_aux_linear_reg_a_en) |-> !st.rail_stat[2];
   endproperty
   a_ldo_gate: assert property (p_ldo_gate)
      else $error("disabled regulator reports fault");

   property p_chg_reset;
      wr_chg_reset |=> st.chg_reset ##1 !st.chg_reset || $past(wr_chg_reset);
   endproperty
   a_chg_reset: assert property (p_chg_reset)
      else $error("charger reset pulse wrong");

   property p_ack_clear;
      ((st.chg_ack & ~st.chg_stat) == 8'h00) && ((st.rail_ack & ~st.rail_stat) == 8'h00);
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("ack set without status");

   property p_read_ack;
      rd_chg |=> ((($past(st.chg_stat) & st.chg_stat) & ~st.chg_ack) == 8'h00);
   endproperty
   a_read_ack: assert property (p_read_ack)
      else $error("read did not acknowledge");

   property p_edge_set;
      $rose(st.chg_sync2[5]) |=> st.chg_stat[5];
   endproperty
   a_edge_set: assert property (p_edge_set)
      else $error("thermal edge not captured");

   property p_rail_rise;
      $rose(st.rail_stat[7]) && !st.mask_rail[7] |=> !o_int_oe_n;
   endproperty
   a_rail_rise: assert property (p_rail_rise)
      else $error("rail rise did not drive pin");

   property p_int_level;
      ##1 o_int_oe_n == !$past(|chg_pending || |rail_pending);
   endproperty
   a_int_level: assert property (p_int_level)
      else $error("interrupt pin mismatch");

   property p_mask_write;
      i_reg_req.wr && (i_reg_req.addr == charger_rail_irq_pkg::ADDR_CHG_MASK) |=>
         st.mask_chg == $past(i_reg_req.wdata);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("charge mask write lost");

   property p_rail_mask_write;
      i_reg_req.wr && (i_reg_req.addr == charger_rail_irq_pkg::ADDR_RAIL_MASK) |=>
         st.mask_rail == $past(i_reg_req.wdata);
   endproperty
   a_rail_mask_write: assert property (p_rail_mask_write)
      else $error("rail mask write lost");

   property p_chg_wr_ignore;
      i_reg_req.wr && (i_reg_req.addr == charger_rail_irq_pkg::ADDR_CHG_STATUS) &&
         ((i_reg_req.wdata & charger_rail_irq_pkg::CHG_RESET_BITS) == 8'h00) |=> !st.chg_reset;
   endproperty
   a_chg_wr_ignore: assert property (p_chg_wr_ignore)
      else $error("ignored status write restarted charger");

   property p_taper_direct;
      !i_taper_timer_en |=> st.chg_stat[charger_rail_irq_pkg::CHG_TAPER_BIT] ==
         $past(st.chg_sync2[charger_rail_irq_pkg::CHG_TAPER_BIT]);
   endproperty
   a_taper_direct: assert property (p_taper_direct)
      else $error("taper bit does not follow comparator");

   property p_taper_wait;
      i_taper_timer_en && !st.taper_done |=> !st.chg_stat[charger_rail_irq_pkg::CHG_TAPER_BIT];
   endproperty
   a_taper_wait: assert property (p_taper_wait)
      else $error("taper reported before timer expired");

   property p_batt_edge;
      $rose(st.chg_sync2[0]) |=> st.chg_stat[0];
   endproperty
   a_batt_edge: assert property (p_batt_edge)
      else $error("battery temperature edge not captured");

   property p_pb_edge;
      $rose(st.rail_sync2[7]) |=> st.rail_stat[7];
   endproperty
   a_pb_edge: assert property (p_pb_edge)
      else $error("push-button edge not captured");

   property p_supply_undervolt_edge;
      $rose(st.rail_sync2[5]) |=> st.rail_stat[5];
   endproperty
   a_supply_undervolt_edge: assert property (p_supply_undervolt_edge)
      else $error("undervoltage edge not captured");

   property p_chg_pin;
      chg_pending != 8'h00 |=> !o_int_oe_n;
   endproperty
   a_chg_pin: assert property (p_chg_pin)
      else $error("pending charge bit did not drive pin");

   c_int_low: cover property (!o_int_oe_n);
   c_ack_release: cover property (!o_int_oe_n ##1 rd_chg ##2 o_int_oe_n);
   c_taper_done: cover property (st.taper_done);
   c_chg_reset: cover property (st.chg_reset);

endmodule : charger_rail_irq_status
`default_nettype wire

// *** verilog/charger_rail_irq_pkg.sv ***
// Constants, carriers and state type for the charger and rail interrupt block
`default_nettype none
package charger_rail_irq_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_CHG_STATUS = 8'h01;
   localparam logic [7:0] ADDR_RAIL_STATUS = 8'h02;
   localparam logic [7:0] ADDR_CHG_MASK = 8'h03;
   localparam logic [7:0] ADDR_RAIL_MASK = 8'h04;
   localparam logic [7:0] ADDR_CHG_ACK = 8'h05;
   localparam logic [7:0] ADDR_RAIL_ACK = 8'h06;
   // Reset values and read value of unmapped addresses
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'hFF;
   localparam logic [7:0] UNMAPPED_READ = 8'hFF;
   // Synchroniser reset for rail pins; the lid pin idles high, so no false edge after reset
   localparam logic [7:0] RAIL_PIN_IDLE = 8'h40;
   // Edge-set positions; others follow the condition level
   localparam logic [7:0] CHG_EDGE_BITS = 8'h21;
   localparam logic [7:0] RAIL_EDGE_BITS = 8'hE0;
   // Field positions
   localparam int CHG_TAPER_BIT = 3;
   localparam int RAIL_UNUSED_BIT = 4;
   localparam logic [7:0] CHG_RESET_BITS = 8'h1E;
   // Taper timer: 30 minutes at 250 MHz
   localparam longint unsigned TAPER_DELAY_MIN = 30;
   localparam longint unsigned CLK_HZ = 250_000_000;
   localparam int TAPER_CNT_W = 40;
   localparam logic [TAPER_CNT_W-1:0] TAPER_DELAY_CYCLES =
      TAPER_CNT_W'(TAPER_DELAY_MIN * 64'd60 * CLK_HZ);

   typedef struct packed {
      logic usb_valid;
      logic adapter_valid;
      logic thermal_suspend;
      logic term_current;
      logic taper_compare;
      logic fast_timeout;
      logic precharge_timeout;
      logic batt_temp_error;
   } chg_cond_t;

   typedef struct packed {
      logic pushbutton_shutdown_request;
      logic battery_lid_sense;
      logic supply_undervolt;
      logic low_power_mode;
      logic aux_linear_reg_b_fault;
      logic aux_linear_reg_a_fault;
      logic main_fault;
      logic core_fault;
   } rail_cond_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [7:0] chg_sync1;
      logic [7:0] chg_sync2;
      logic [7:0] chg_prev;
      logic [7:0] rail_sync1;
      logic [7:0] rail_sync2;
      logic [7:0] rail_prev;
      logic [7:0] chg_stat;
      logic [7:0] rail_stat;
      logic [7:0] mask_chg;
      logic [7:0] mask_rail;
      logic [7:0] chg_ack;
      logic [7:0] rail_ack;
      logic [7:0] rdata;
      logic int_oe_n;
      logic int_drive;
      logic chg_reset;
      logic [TAPER_CNT_W-1:0] taper_cnt;
      logic taper_done;
   } state_t;

   localparam state_t STATE_RESET = '{
      mask_chg: MASK_RESET,
      mask_rail: MASK_RESET,
      rail_sync1: RAIL_PIN_IDLE,
      rail_sync2: RAIL_PIN_IDLE,
      int_oe_n: 1'b1,
      default: '0
   };
endpackage : charger_rail_irq_pkg
`default_nettype wire

// *** tb/reg_host.sv ***
// Register master model standing in for the processor on the serial link
`timescale 1ns/1ps
`default_nettype none
module reg_host (
   // Clock
   input wire logic i_mclk,
   // Register port
   output var charger_rail_irq_pkg::reg_req_t o_req,
   input wire logic [7:0] i_rdata
);
   initial o_req = '0;

   // Byte write: strobe held across exactly one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_mclk);
      o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge i_mclk);
      o_req = '0;
   endtask : wr

   // Byte read: data is registered, so it is taken one cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_mclk);
      o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge i_mclk);
      o_req = '0;
      @(negedge i_mclk);
      d = i_rdata;
   endtask : rd
endmodule : reg_host
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the charger and rail interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_mclk = 1'b0;
   logic i_reset = 1'b1;
   charger_rail_irq_pkg::reg_req_t req;
   charger_rail_irq_pkg::chg_cond_t chg = '0;
   charger_rail_irq_pkg::rail_cond_t rail = 8'h40;
   logic tmr_en = 1'b0;
   logic en_a = 1'b0;
   logic en_b = 1'b0;
   logic lp_sel = 1'b0;
   logic [7:0] rdata;
   logic [7:0] v;
   logic rst_pulse;
   logic seen_rst = 1'b0;
   logic int_out;
   logic int_oe_n;
   int bad_count = 0;
   int n_tests = 0;
   // Address in the upper byte, expected read value in the lower
   logic [15:0] rows [6] = '{16'h0100, 16'h0200, 16'h03FF, 16'h04FF, 16'h0500, 16'h20FF};

   always #2 i_mclk = ~i_mclk;
   always @(posedge i_mclk) if (rst_pulse === 1'b1) seen_rst <= 1'b1;

   charger_rail_irq_status #(.TAPER_DELAY_CYCLES(40'h10)) uut (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_reg_req(req), .o_reg_rdata(rdata),
      .i_chg_cond(chg), .i_rail_cond(rail), .i_taper_timer_en(tmr_en),
      .i_aux_linear_reg_a_en(en_a), .i_aux_linear_reg_b_en(en_b),
      .i_core_lowpower_sel(lp_sel), .o_charger_reset(rst_pulse), .o_int_out(int_out),
      .o_int_oe_n(int_oe_n));
   reg_host host (.i_mclk(i_mclk), .o_req(req), .i_rdata(rdata));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, v);
      check(v, exp);
   endtask : rdchk

   // Sync, status and pin stages all land within this span
   task automatic settle();
      repeat (6) @(negedge i_mclk);
   endtask : settle

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (12) @(negedge i_mclk);
      i_reset = 1'b0;
      check({7'h00, int_oe_n}, 8'h01);
      foreach (rows[i]) begin
         rdchk(rows[i][15:8], rows[i][7:0]);
      end
      $display("Test reset values done");
      chg.usb_valid = 1'b1;
      settle();
      check({7'h00, int_oe_n}, 8'h01);
      host.wr(8'h03, 8'h7F);
      settle();
      check({7'h00, int_oe_n}, 8'h00);
      check({7'h00, int_out}, 8'h00);
      rdchk(8'h01, 8'h80);
      settle();
      check({7'h00, int_oe_n}, 8'h01);
      rdchk(8'h05, 8'h80);
      chg.usb_valid = 1'b0;
      settle();
      rdchk(8'h05, 8'h00);
      $display("Test charge level and acknowledge done");
      host.wr(8'h04, 8'h7F);
      rail = 8'hE0;
      settle();
      rail = 8'h40;
      settle();
      check({7'h00, int_oe_n}, 8'h00);
      rdchk(8'h02, 8'hA0);
      settle();
      check({7'h00, int_oe_n}, 8'h01);
      rdchk(8'h02, 8'h00);
      rail = 8'h54;
      lp_sel = 1'b1;
      settle();
      rdchk(8'h02, 8'h01);
      rdchk(8'h06, 8'h01);
      en_a = 1'b1;
      settle();
      rdchk(8'h02, 8'h05);
      rail = 8'h48;
      settle();
      rdchk(8'h02, 8'h00);
      en_b = 1'b1;
      settle();
      rdchk(8'h02, 8'h08);
      rail = 8'h42;
      lp_sel = 1'b0;
      settle();
      rdchk(8'h02, 8'h02);
      $display("Test rail status done");
      chg = 8'h57;
      settle();
      rdchk(8'h01, 8'h57);
      chg = 8'h20;
      settle();
      rdchk(8'h01, 8'h20);
      chg = '0;
      host.wr(8'h01, 8'hE1);
      settle();
      check({7'h00, seen_rst}, 8'h00);
      host.wr(8'h01, 8'h02);
      settle();
      check({7'h00, seen_rst}, 8'h01);
      rdchk(8'h01, 8'h00);
      $display("Test charge bits and charger reset done");
      chg.taper_compare = 1'b1;
      settle();
      rdchk(8'h01, 8'h08);
      chg.taper_compare = 1'b0;
      tmr_en = 1'b1;
      settle();
      chg.taper_compare = 1'b1;
      settle();
      rdchk(8'h01, 8'h00);
      repeat (24) @(negedge i_mclk);
      rdchk(8'h01, 8'h08);
      $display("Test taper timer done");
      chg = '0;
      tmr_en = 1'b0;
      host.wr(8'h04, 8'h00);
      rail = 8'hC0;
      settle();
      check({7'h00, int_oe_n}, 8'h00);
      i_reset = 1'b1;
      rail = 8'h40;
      repeat (3) @(negedge i_mclk);
      i_reset = 1'b0;
      check({7'h00, int_oe_n}, 8'h01);
      foreach (rows[i]) begin
         rdchk(rows[i][15:8], rows[i][7:0]);
      end
      $display("Test mid-run reset done");
      close_out();
   end

   initial begin
      #40000;
      bad_count++;
      close_out();
   end
endmodule : tb_top
`default_nettype wire
